// ### logic/wdlp_pkg.sv
package wdlp_pkg;

	// Register map: printed offset is a word index, byte address is 4x
	localparam logic [7:0] WDLP_CTRL_IDX   = 8'h2A;
	localparam int         WDLP_ADR_W      = 10;
	localparam logic [7:0] WDLP_CTRL_RST   = 8'h7F;

	// Control register field layout
	localparam int         WDLP_ACT_BIT    = 7;
	localparam int         WDLP_TOP_BIT    = 6;
	localparam int         WDLP_CNT_W      = 7;
	localparam logic [6:0] WDLP_CNT_ROLL   = 7'h40;

	// Clock and timing
	localparam int         WDLP_CLK_MHZ    = 20;
	localparam int         WDLP_PRESCALE   = 16384;
	localparam int         WDLP_RST_NS     = 30000;
	localparam int         WDLP_RST_CYC    =
		(WDLP_RST_NS * WDLP_CLK_MHZ + 999) / 1000;
	localparam int         WDLP_PLS_W      = 10;

	// Wake-up delays in CPU clocks
	localparam int         WDLP_DLY_W      = 13;
	localparam logic [12:0] WDLP_DLY_SHORT = 13'h0100;
	localparam logic [12:0] WDLP_DLY_HALT  = 13'h0190;
	localparam logic [12:0] WDLP_DLY_AHALT = 13'h1000;

	// Power mode states, Gray coded in the order run-halt-wake-active halt
	typedef enum logic [1:0] {
		WDLP_RUN   = 2'b00,
		WDLP_HALT  = 2'b01,
		WDLP_WAKE  = 2'b11,
		WDLP_AHALT = 2'b10
	} wdlp_state_e;

	// Wake delay chosen by mode left and startup selection
	function automatic logic [12:0] wdlp_delay(
		input logic from_ahalt,
		input logic long_sel
	);
		if (!long_sel)
			return WDLP_DLY_SHORT;
		return from_ahalt ? WDLP_DLY_AHALT : WDLP_DLY_HALT;
	endfunction

endpackage

// ### logic/wdlp_top.sv
`timescale 1ns/10ps
// Operation
// - Plain halt: one decrement, then frozen, no reset
// - Halt exit by interrupt: delayed counting restart
// - Reset ends halt: disabled unless hardware option
// - Halt with reset option: reset instead
// - Timebase enabled halt: active halt, counter frozen
// - Active halt interrupt exit: count resumes immediately
// - Reset ends active halt: delayed counting restart
// - Hardware option: always active, activation bit ignored
// - Activation bit set by software, cleared by reset
// - Reset only while activation bit is one, except halt with reset option
// - Seven-bit counter, one decrement per prescale period
// - Reset when counter passes 40h to 3Fh
// - Control register at 2Ah, resets to 7Fh
// - Counter runs even while not activated
// - Writing active with top bit clear forces reset
// - Watchdog reset drives pin low about 30us
module wdlp_top
	import wdlp_pkg::*;
#(
	parameter int PRESCALE_CYC = WDLP_PRESCALE
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [WDLP_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  halt_exec_i,
	input  wire logic                  timebase_irq_enable_i,
	input  wire logic                  timebase_irq_i,
	input  wire logic                  ext_irq_i,
	input  wire logic                  wake_rst_i,
	input  wire logic                  halt_reset_option_i,
	input  wire logic                  hw_watchdog_opt_i,
	input  wire logic                  long_startup_i,
	output logic                       wdg_rst_o,
	output logic                       wdg_rst_pin_n_o,
	output logic                       counting_o
);

	localparam int PRE_W = $clog2(PRESCALE_CYC);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE_CYC - 1);
	localparam logic [WDLP_PLS_W-1:0] PLS_LAST =
		WDLP_PLS_W'(WDLP_RST_CYC - 1);

	wdlp_state_e                 st_q;
	wdlp_state_e                 st_d;
	logic [WDLP_CNT_W-1:0]       cnt_q;
	logic                        act_q;
	logic                        hro_q;
	logic                        hwo_q;
	logic [PRE_W-1:0]            pre_q;
	logic [WDLP_DLY_W-1:0]       dly_q;
	logic [WDLP_PLS_W-1:0]       pls_q;
	logic                        rst_q;
	logic                        pin_n_q;
	logic                        run_q;
	logic [WDLP_DLY_W-1:0]       wake_n_q;
	logic [WDLP_DLY_W-1:0]       wake_lim_q;
	logic                        ack_q;
	logic [31:0]                 rdat_q;
	logic                        req;
	logic                        hit;
	logic                        wr_hit;
	logic                        act_eff;
	logic                        tick;
	logic                        dec_en;
	logic                        halt_plain;
	logic                        halt_rst;
	logic                        roll_rst;
	logic                        sw_rst;
	logic                        fire;

	// Bus request decode, one word at the control index
	assign req    = wb_cyc_i && wb_stb_i && !ack_q;
	assign hit    = (wb_adr_i[WDLP_ADR_W-1:2] == WDLP_CTRL_IDX);
	assign wr_hit = req && hit && wb_we_i && wb_sel_i[0];

	// Option straps caught while reset is held
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			hro_q <= halt_reset_option_i;
			hwo_q <= hw_watchdog_opt_i;
		end
	end

	// Effective activation, forced by hardware option
	assign act_eff = act_q || hwo_q;

	// Halt instruction decode in run mode
	assign halt_plain = (st_q == WDLP_RUN) && halt_exec_i &&
		!timebase_irq_enable_i && !hro_q;
	assign halt_rst   = (st_q == WDLP_RUN) && halt_exec_i &&
		!timebase_irq_enable_i && hro_q;

	// Prescale tick only while counting is allowed
	assign tick   = (st_q == WDLP_RUN) && (pre_q == PRE_LAST);
	assign dec_en = (tick || halt_plain) && !wr_hit;

	// Reset causes; the halt-entry decrement never fires
	assign roll_rst = tick && !wr_hit && act_eff &&
		(cnt_q == WDLP_CNT_ROLL);
	assign sw_rst   = wr_hit && (wb_dat_i[WDLP_ACT_BIT] || act_eff) &&
		!wb_dat_i[WDLP_TOP_BIT];
	assign fire     = roll_rst || sw_rst || halt_rst;

	// Power mode sequencing
	always_comb begin
		st_d = st_q;
		case (st_q)
			WDLP_RUN: begin
				if (halt_exec_i && !halt_rst) begin
					if (timebase_irq_enable_i)
						st_d = WDLP_AHALT;
					else
						st_d = WDLP_HALT;
				end
			end
			WDLP_HALT: begin
				if (wake_rst_i)
					st_d = WDLP_RUN;
				else if (ext_irq_i)
					st_d = WDLP_WAKE;
			end
			WDLP_AHALT: begin
				if (wake_rst_i)
					st_d = WDLP_WAKE;
				else if (timebase_irq_i || ext_irq_i)
					st_d = WDLP_RUN;
			end
			WDLP_WAKE: begin
				if (dly_q == '0)
					st_d = WDLP_RUN;
			end
			default: st_d = WDLP_RUN;
		endcase
	end

	// Mode register
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			st_q  <= WDLP_RUN;
			run_q <= 1'b1;
		end else begin
			st_q  <= st_d;
			run_q <= (st_d == WDLP_RUN); // Registered run flag
		end
	end

	// Wake-up delay counter
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			dly_q <= '0;
		else if (st_q == WDLP_HALT && st_d == WDLP_WAKE)
			dly_q <= wdlp_delay(1'b0, long_startup_i) - 13'h0001;
		else if (st_q == WDLP_AHALT && st_d == WDLP_WAKE)
			dly_q <= wdlp_delay(1'b1, long_startup_i) - 13'h0001;
		else if (st_q == WDLP_WAKE && dly_q != '0)
			dly_q <= dly_q - 13'h0001;
	end

	// Prescaler, restarted by every control write
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || wake_rst_i || wr_hit)
			pre_q <= '0;
		else if (tick)
			pre_q <= '0;
		else if (st_q == WDLP_RUN)
			pre_q <= pre_q + PRE_W'(1);
	end

	// Free-running downcounter
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || wake_rst_i)
			cnt_q <= WDLP_CTRL_RST[6:0];
		else if (wr_hit)
			cnt_q <= wb_dat_i[6:0];
		else if (dec_en)
			cnt_q <= cnt_q - 7'h01;
	end

	// Activation bit: software sets, only reset clears
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || wake_rst_i)
			act_q <= 1'b0;
		else if (wr_hit && wb_dat_i[WDLP_ACT_BIT])
			act_q <= 1'b1;
	end

	// Reset pulse stretcher; a new cause during a pulse is ignored
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			rst_q   <= 1'b0;
			pin_n_q <= 1'b1;
			pls_q   <= '0;
		end else if (!rst_q && fire) begin
			rst_q   <= 1'b1;
			pin_n_q <= 1'b0;
			pls_q   <= PLS_LAST;
		end else if (rst_q) begin
			if (pls_q == '0) begin
				rst_q   <= 1'b0;
				pin_n_q <= 1'b1;
			end else
				pls_q <= pls_q - 10'h001;
		end
	end

	// Bus answer: one wait state, unmapped reads give zero
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= req;
			if (req && hit && !wb_we_i)
				rdat_q <= {24'h00_0000, act_eff, cnt_q};
			else if (req)
				rdat_q <= 32'h0000_0000;
		end
	end

	// Outputs, all from flops; no interrupt line exists
	assign wb_ack_o        = ack_q;
	assign wb_dat_o        = rdat_q;
	assign wdg_rst_o       = rst_q;
	assign wdg_rst_pin_n_o = pin_n_q;
	assign counting_o      = run_q;

	// Check helper: cycles spent in wake so far
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || st_q != WDLP_WAKE)
			wake_n_q <= '0;
		else
			wake_n_q <= wake_n_q + 13'h0001;
	end

	// Check helper: wake length owed for the mode being left
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			wake_lim_q <= WDLP_DLY_SHORT;
		else if (st_q != WDLP_WAKE)
			wake_lim_q <= !long_startup_i ? WDLP_DLY_SHORT :
				(st_q == WDLP_AHALT) ? WDLP_DLY_AHALT : WDLP_DLY_HALT;
	end

	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);

	halt_freeze_a: assert property (
		(st_q == WDLP_HALT && $past(st_q) == WDLP_HALT && !wr_hit &&
		 !wake_rst_i) |=> (cnt_q == $past(cnt_q)) && !$rose(rst_q))
		else $error("counter moved in halt");

	halt_wake_dly_a: assert property (
		(st_q == WDLP_HALT && ext_irq_i && !wake_rst_i) |=>
		(st_q == WDLP_WAKE) && (dly_q == (($past(long_startup_i) ?
		 WDLP_DLY_HALT : WDLP_DLY_SHORT) - 13'h0001)) ##1
		(cnt_q == $past(cnt_q)))
		else $error("halt wake delay wrong");

	halt_wake_len_a: assert property (
		(st_q == WDLP_WAKE && st_d == WDLP_RUN) |->
		wake_n_q == wake_lim_q - 13'h0001)
		else $error("wake length wrong");

	rst_disable_a: assert property (
		wake_rst_i |=> !act_q && (cnt_q == WDLP_CTRL_RST[6:0]))
		else $error("reset left watchdog active");

	halt_opt_rst_a: assert property (
		(halt_rst && !rst_q) |=> rst_q && (st_q == WDLP_RUN))
		else $error("halt with option did not reset");

	ahalt_freeze_a: assert property (
		(st_q == WDLP_AHALT && !wr_hit && !wake_rst_i) |=>
		cnt_q == $past(cnt_q))
		else $error("counter moved in active halt");

	ahalt_wake_a: assert property (
		(st_q == WDLP_AHALT && !wake_rst_i &&
		 (timebase_irq_i || ext_irq_i)) |=> st_q == WDLP_RUN)
		else $error("active halt wake delayed");

	ahalt_rst_dly_a: assert property (
		(st_q == WDLP_AHALT && wake_rst_i) |=>
		(st_q == WDLP_WAKE) && (dly_q == wdlp_delay(1'b1,
		 $past(long_startup_i)) - 13'h0001))
		else $error("active halt reset delay wrong");

	hw_opt_act_a: assert property (
		(hwo_q && tick && !wr_hit &&
		 cnt_q == WDLP_CNT_ROLL && !rst_q) |=> rst_q)
		else $error("hardware option did not reset");

	act_sticky_a: assert property (
		(act_q && !wake_rst_i) |=> act_q)
		else $error("activation bit cleared");

	inact_no_rst_a: assert property (
		$rose(rst_q) |-> $past(act_eff || halt_rst ||
		 (wr_hit && wb_dat_i[WDLP_ACT_BIT])))
		else $error("reset while inactive");

	tick_period_a: assert property (
		(st_q == WDLP_RUN && pre_q != PRE_LAST && !halt_exec_i &&
		 !wr_hit && !wake_rst_i) |=> cnt_q == $past(cnt_q) &&
		pre_q == $past(pre_q) + PRE_W'(1))
		else $error("prescale period wrong");

	roll_rst_a: assert property (
		(tick && !wr_hit && act_eff && cnt_q == WDLP_CNT_ROLL &&
		 !rst_q) |=> rst_q && (cnt_q == 7'h3F))
		else $error("no reset at rollover");

	free_run_a: assert property (
		(tick && !wr_hit && !act_eff && !wake_rst_i) |=>
		cnt_q == $past(cnt_q) - 7'h01)
		else $error("counter stopped while inactive");

	sw_force_a: assert property (
		(wr_hit && wb_dat_i[WDLP_ACT_BIT] && !wb_dat_i[WDLP_TOP_BIT] &&
		 !rst_q) |=> rst_q)
		else $error("forced reset missing");

	pulse_len_a: assert property (
		$rose(rst_q) |-> (pls_q == PLS_LAST) && !wdg_rst_pin_n_o)
		else $error("reset pulse length wrong");

	pulse_end_a: assert property (
		(rst_q && pls_q == '0) |=> !rst_q && wdg_rst_pin_n_o)
		else $error("reset pulse did not end");

	wr_load_a: assert property (
		(wr_hit && !wake_rst_i) |=> (cnt_q == $past(wb_dat_i[6:0])) &&
		(pre_q == '0))
		else $error("write did not load counter");

	halt_entry_c: cover property (
		st_q == WDLP_RUN ##1 st_q == WDLP_HALT);
	ahalt_exit_c: cover property (
		st_q == WDLP_AHALT ##1 st_q == WDLP_RUN);
	roll_rst_c: cover property (roll_rst && !rst_q);
	sw_force_c: cover property (sw_rst && !rst_q);

endmodule // wdlp_top

// ### bench/test_wdlp_top.sv
`timescale 1ns/10ps
module test_wdlp_top;
	import wdlp_pkg::*;

	localparam logic [9:0] ADR = 10'h0A8;
	logic        clk   = 1'b0;
	logic        srst  = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [9:0]  adr   = '0;
	logic [3:0]  sel   = 4'h0;
	logic [31:0] wdat  = '0;
	logic        halt  = 1'b0;
	logic        tbie  = 1'b0;
	logic        tbirq = 1'b0;
	logic        eirq  = 1'b0;
	logic        wrst  = 1'b0;
	logic        hro   = 1'b0;
	logic        hwo   = 1'b0;
	logic        lsel  = 1'b0;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic        ack;
	logic        rst_o;
	logic        pin_n;
	logic        run;
	int          n_fail     = 0;
	int          n_compared = 0;
	int          n;

	// Short prescaler keeps the run brief
	wdlp_top #(.PRESCALE_CYC(8)) u_dut (
		.ref_clk_i(clk), .srst_i(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .halt_exec_i(halt),
		.timebase_irq_enable_i(tbie), .timebase_irq_i(tbirq),
		.ext_irq_i(eirq), .wake_rst_i(wrst), .halt_reset_option_i(hro),
		.hw_watchdog_opt_i(hwo), .long_startup_i(lsel),
		.wdg_rst_o(rst_o), .wdg_rst_pin_n_o(pin_n), .counting_o(run)
	);

	// Clock, 50 ns period
	always #25 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// Classic single Wishbone cycle, waits for ack
	task automatic wb(input logic w, input logic [9:0] a,
			input logic [7:0] d, input logic [3:0] s);
		int k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {24'h0, d};
		@(posedge clk);
		while (ack !== 1'b1 && k < 100) begin
			@(posedge clk);
			k++;
		end
		rd = rdat;
		if (k >= 100)
			n_fail++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// One-cycle event: 0 halt, 1 ext irq, 2 timebase irq, 3 wake reset
	task automatic pulse(input int which);
		@(posedge clk);
		case (which)
		0: halt <= 1'b1;
		1: eirq <= 1'b1;
		2: tbirq <= 1'b1;
		default: wrst <= 1'b1;
		endcase
		@(posedge clk);
		{halt, eirq, tbirq, wrst} <= 4'h0;
		#1;
	endtask

	// Cycles until counting resumes
	task automatic run_wait(output int c);
		c = 0;
		while (run !== 1'b1 && c < 5000) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask

	// Reset with option straps, held six cycles
	task automatic do_rst(input logic o_hro, input logic o_hw);
		@(posedge clk);
		srst <= 1'b1;
		hro <= o_hro;
		hwo <= o_hw;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test();
	end

	// Test sequence
	initial begin
		do_rst(1'b0, 1'b0);
		wb(1'b0, ADR, 8'h00, 4'h1);
		chk(rd, 32'h7F);
		wb(1'b0, 10'h0AC, 8'h00, 4'h1);
		chk(rd, 32'h0);
		wb(1'b1, 10'h0AC, 8'hBF, 4'h1);
		wb(1'b1, ADR, 8'hBF, 4'h0);
		chk(rst_o, 1'b0);
		wb(1'b1, ADR, 8'h41, 4'h1);
		repeat (18) @(posedge clk);
		wb(1'b0, ADR, 8'h00, 4'h1);
		chk(rd, 32'h3F);
		chk(rst_o, 1'b0);
		done("count");
		wb(1'b1, ADR, 8'hFF, 4'h1);
		wb(1'b1, ADR, 8'h7F, 4'h1);
		wb(1'b0, ADR, 8'h00, 4'h1);
		chk(rd, 32'hFF);
		wb(1'b1, ADR, 8'hC1, 4'h1);
		n = 0;
		while (rst_o !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n >= 14 && n <= 18, 1'b1);
		chk(pin_n, 1'b0);
		n = 0;
		while (rst_o === 1'b1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n, 600);
		do_rst(1'b0, 1'b0);
		wb(1'b1, ADR, 8'hBF, 4'h1);
		#1;
		chk(rst_o, 1'b1);
		done("reset");
		do_rst(1'b0, 1'b0);
		for (int i = 0; i < 2; i++) begin
			lsel <= i[0];
			wb(1'b1, ADR, 8'h7F, 4'h1);
			pulse(0);
			chk(run, 1'b0);
			repeat (40) @(posedge clk);
			wb(1'b0, ADR, 8'h00, 4'h1);
			chk(rd, 32'h7E);
			pulse(1);
			run_wait(n);
			chk(n, i ? 400 : 256);
		end
		done("halt");
		tbie <= 1'b1;
		for (int i = 1; i <= 2; i++) begin
			wb(1'b1, ADR, 8'h7F, 4'h1);
			pulse(0);
			chk(run, 1'b0);
			repeat (40) @(posedge clk);
			wb(1'b0, ADR, 8'h00, 4'h1);
			chk(rd, 32'h7F);
			pulse(i);
			run_wait(n);
			chk(n, 0);
		end
		for (int i = 0; i < 2; i++) begin
			lsel <= i[0];
			pulse(0);
			pulse(3);
			run_wait(n);
			chk(n, i ? 4096 : 256);
		end
		done("active_halt");
		do_rst(1'b1, 1'b0);
		pulse(0);
		chk({rst_o, run}, 2'b00);
		pulse(2);
		tbie <= 1'b0;
		pulse(0);
		chk(rst_o, 1'b1);
		do_rst(1'b0, 1'b0);
		wb(1'b1, ADR, 8'hFF, 4'h1);
		pulse(0);
		pulse(3);
		wb(1'b0, ADR, 8'h00, 4'h1);
		chk(rd, 32'h7F);
		do_rst(1'b0, 1'b1);
		wb(1'b1, ADR, 8'h7F, 4'h1);
		wb(1'b0, ADR, 8'h00, 4'h1);
		chk(rd, 32'hFF);
		wb(1'b1, ADR, 8'h41, 4'h1);
		n = 0;
		while (rst_o !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n >= 14 && n <= 18, 1'b1);
		do_rst(1'b0, 1'b1);
		pulse(0);
		pulse(3);
		wb(1'b0, ADR, 8'h00, 4'h1);
		chk(rd, 32'hFF);
		wb(1'b1, ADR, 8'h3F, 4'h1);
		#1;
		chk(rst_o, 1'b1);
		done("options");
		finish_test();
	end

endmodule // test_wdlp_top
